// ---- oscsc_top.sv ----
// What this block does
// [RL1] Answers peripheral 4, byte accesses only
// [RL2] Decodes three registers at 0x00-0x02
// [RL3] Source select bit, reset from strap
// [RL4] Optional tile reset on select change
// [RL5] Internal oscillator speed bit, resets fast
// [RL6] Internal oscillator enable, resets on
// [RL7] Crystal bias enable, resets on
// [RL8] Crystal oscillator enable, resets on
// [RL9] Bits 7 to 2 read zero
`timescale 1ns/1ns
module oscsc_top (
    input  wire logic                  clk,
    input  wire logic                  rst,
    input  wire logic                  strap_src_pin,
    input  wire oscsc_pkg::oscsc_req_t req,
    output logic                       rd_valid,
    output logic [7:0]                 rd_data,
    output oscsc_pkg::oscsc_ctrl_t     ctrl,
    output logic                       tile_reset
);
    // Strap synchroniser
    logic strap_meta;
    logic strap_sync;
    logic rst_d;
    always_ff @(posedge clk) begin
        strap_meta <= strap_src_pin;
        strap_sync <= strap_meta;
    end

    // Register state
    logic       src_sel;
    logic       rst_on_chg;
    logic       int_slow;
    logic       int_en;
    logic       xtal_bias;
    logic       xtal_en;

    // Next values
    logic       next_src_sel;
    logic       next_rst_on_chg;
    logic       next_int_slow;
    logic       next_int_en;
    logic       next_xtal_bias;
    logic       next_xtal_en;
    logic       next_tile_reset;
    logic       next_rd_valid;
    logic [7:0] next_rd_data;
    logic       hit;

    // Read data for one offset; reserved bits stay zero
    function automatic logic [7:0] read_mux(input logic [7:0] a,
                                            input logic       s,
                                            input logic       rc,
                                            input logic       sl,
                                            input logic       ie,
                                            input logic       xb,
                                            input logic       xe);
        logic [7:0] r;
        r = oscsc_pkg::ZERO_BYTE; // see [RL9]
        unique case (a)
            oscsc_pkg::OFF_GENERAL: begin
                r[oscsc_pkg::BIT_SRC_SEL]    = s;
                r[oscsc_pkg::BIT_RST_ON_CHG] = rc;
            end
            oscsc_pkg::OFF_INTERNAL: begin
                r[oscsc_pkg::BIT_INT_EN]   = ie;
                r[oscsc_pkg::BIT_INT_SLOW] = sl;
            end
            oscsc_pkg::OFF_CRYSTAL: begin
                r[oscsc_pkg::BIT_XTAL_EN]   = xe;
                r[oscsc_pkg::BIT_XTAL_BIAS] = xb;
            end
            default: r = oscsc_pkg::ZERO_BYTE;
        endcase
        return r;
    endfunction : read_mux

    assign hit = req.valid && (req.periph == oscsc_pkg::PERIPH_ID); // see [RL1]

    // Next-state for registers and read port
    always_comb begin
        next_src_sel    = src_sel;
        next_rst_on_chg = rst_on_chg;
        next_int_slow   = int_slow;
        next_int_en     = int_en;
        next_xtal_bias  = xtal_bias;
        next_xtal_en    = xtal_en;
        next_rd_valid   = hit && !req.write;
        next_rd_data    = rd_data;
        if (hit && req.write) begin
            unique case (req.addr) // see [RL2]
                oscsc_pkg::OFF_GENERAL: begin
                    next_src_sel    = req.wdata[oscsc_pkg::BIT_SRC_SEL];    // see [RL3]
                    next_rst_on_chg = req.wdata[oscsc_pkg::BIT_RST_ON_CHG]; // see [RL4]
                end
                oscsc_pkg::OFF_INTERNAL: begin
                    next_int_en   = req.wdata[oscsc_pkg::BIT_INT_EN];   // see [RL6]
                    next_int_slow = req.wdata[oscsc_pkg::BIT_INT_SLOW]; // see [RL5]
                end
                oscsc_pkg::OFF_CRYSTAL: begin
                    next_xtal_en   = req.wdata[oscsc_pkg::BIT_XTAL_EN];   // see [RL8]
                    next_xtal_bias = req.wdata[oscsc_pkg::BIT_XTAL_BIAS]; // see [RL7]
                end
                default: ;
            endcase
        end
        if (hit && !req.write) begin
            next_rd_data = read_mux(req.addr, src_sel, rst_on_chg, int_slow, int_en,
                                    xtal_bias, xtal_en);
        end
        // Source select loads the strap the cycle after reset release
        if (rst_d) begin
            next_src_sel = strap_sync; // see [RL3]
        end
        next_tile_reset = rst_on_chg && (next_src_sel != src_sel) && !rst_d; // see [RL4]
    end

    // Register update
    always_ff @(posedge clk) begin
        if (rst) begin
            rst_d      <= 1'b1;
            src_sel    <= 1'b0;
            rst_on_chg <= oscsc_pkg::RST_RST_ON_CHG;
            int_slow   <= oscsc_pkg::RST_INT_SLOW;
            int_en     <= oscsc_pkg::RST_INT_EN;
            xtal_bias  <= oscsc_pkg::RST_XTAL_BIAS;
            xtal_en    <= oscsc_pkg::RST_XTAL_EN;
            tile_reset <= 1'b0;
            rd_valid   <= 1'b0;
            rd_data    <= oscsc_pkg::ZERO_BYTE;
        end else begin
            rst_d      <= 1'b0;
            src_sel    <= next_src_sel;
            rst_on_chg <= next_rst_on_chg;
            int_slow   <= next_int_slow;
            int_en     <= next_int_en;
            xtal_bias  <= next_xtal_bias;
            xtal_en    <= next_xtal_en;
            tile_reset <= next_tile_reset;
            rd_valid   <= next_rd_valid;
            rd_data    <= next_rd_data;
        end
    end

    // Control outputs
    assign ctrl.src_internal = src_sel;
    assign ctrl.int_en       = int_en;
    assign ctrl.int_slow     = int_slow;
    assign ctrl.xtal_en      = xtal_en;
    assign ctrl.xtal_bias_en = xtal_bias;

    // Checks
    a_reserved_zero: assert property (@(posedge clk) disable iff (rst) // see [RL9]
        rd_valid |-> rd_data[7:2] == 6'h00) else $error("reserved bits nonzero");
    a_other_periph: assert property (@(posedge clk) disable iff (rst) // see [RL1]
        (req.valid && req.periph != oscsc_pkg::PERIPH_ID) |=> !rd_valid && $stable(ctrl))
        else $error("foreign access acted");
    a_read_ack: assert property (@(posedge clk) disable iff (rst) // see [RL2]
        (hit && !req.write) |=> rd_valid) else $error("read not answered");
    a_tile_rst: assert property (@(posedge clk) disable iff (rst || rst_d) // see [RL4]
        ($changed(src_sel) && $past(rst_on_chg) && !$past(rst_d)) |-> tile_reset)
        else $error("missing tile reset");
    a_no_tile_rst: assert property (@(posedge clk) disable iff (rst) // see [RL4]
        tile_reset |-> $changed(src_sel)) else $error("spurious tile reset");
    a_slow_write: assert property (@(posedge clk) disable iff (rst) // see [RL5]
        (hit && req.write && req.addr == oscsc_pkg::OFF_INTERNAL)
        |=> ctrl.int_slow == $past(req.wdata[oscsc_pkg::BIT_INT_SLOW]))
        else $error("speed not written");
    a_reset_vals: assert property (@(posedge clk) // see [RL4] [RL5] [RL6] [RL7] [RL8]
        $fell(rst) |-> ctrl.int_en && !ctrl.int_slow && ctrl.xtal_en && ctrl.xtal_bias_en
        && !rst_on_chg) else $error("bad reset values");
    a_xtal_write: assert property (@(posedge clk) disable iff (rst) // see [RL7] [RL8]
        (hit && req.write && req.addr == oscsc_pkg::OFF_CRYSTAL)
        |=> ctrl.xtal_en == $past(req.wdata[oscsc_pkg::BIT_XTAL_EN])
            && ctrl.xtal_bias_en == $past(req.wdata[oscsc_pkg::BIT_XTAL_BIAS]))
        else $error("crystal ctrl not written");
    a_strap_load: assert property (@(posedge clk) disable iff (rst) // see [RL3]
        rst_d |=> src_sel == $past(strap_sync)) else $error("strap not loaded");

    // Write paths land one cycle after the request
    a_int_en_write: assert property (@(posedge clk) disable iff (rst) // see [RL6]
        (hit && req.write && req.addr == oscsc_pkg::OFF_INTERNAL)
        |=> ctrl.int_en == $past(req.wdata[oscsc_pkg::BIT_INT_EN]))
        else $error("enable not written");
    a_general_write: assert property (@(posedge clk) disable iff (rst) // see [RL3] [RL4]
        (hit && req.write && req.addr == oscsc_pkg::OFF_GENERAL && !rst_d)
        |=> ctrl.src_internal == $past(req.wdata[oscsc_pkg::BIT_SRC_SEL])
            && rst_on_chg == $past(req.wdata[oscsc_pkg::BIT_RST_ON_CHG]))
        else $error("general ctrl not written");

    // Read data follows the stored fields
    a_read_general: assert property (@(posedge clk) disable iff (rst) // see [RL3] [RL4]
        (hit && !req.write && req.addr == oscsc_pkg::OFF_GENERAL)
        |=> rd_data[oscsc_pkg::BIT_SRC_SEL] == $past(src_sel)
            && rd_data[oscsc_pkg::BIT_RST_ON_CHG] == $past(rst_on_chg))
        else $error("general ctrl read wrong");
    a_read_internal: assert property (@(posedge clk) disable iff (rst) // see [RL5] [RL6]
        (hit && !req.write && req.addr == oscsc_pkg::OFF_INTERNAL)
        |=> rd_data[oscsc_pkg::BIT_INT_EN] == $past(int_en)
            && rd_data[oscsc_pkg::BIT_INT_SLOW] == $past(int_slow))
        else $error("internal ctrl read wrong");
    a_read_crystal: assert property (@(posedge clk) disable iff (rst) // see [RL7] [RL8]
        (hit && !req.write && req.addr == oscsc_pkg::OFF_CRYSTAL)
        |=> rd_data[oscsc_pkg::BIT_XTAL_EN] == $past(xtal_en)
            && rd_data[oscsc_pkg::BIT_XTAL_BIAS] == $past(xtal_bias))
        else $error("crystal ctrl read wrong");
    a_unmapped_read: assert property (@(posedge clk) disable iff (rst) // see [RL2] [RL9]
        (hit && !req.write && req.addr > oscsc_pkg::OFF_CRYSTAL)
        |=> rd_data == oscsc_pkg::ZERO_BYTE)
        else $error("unmapped read not zero");

    // Read port stays quiet on writes and in reset
    a_write_no_read: assert property (@(posedge clk) disable iff (rst) // see [RL2]
        (hit && req.write) |=> !rd_valid)
        else $error("write answered as read");
    a_rd_data_hold: assert property (@(posedge clk) disable iff (rst) // see [RL2]
        !(hit && !req.write) |=> $stable(rd_data))
        else $error("read data moved");
    a_reset_quiet: assert property (@(posedge clk) // see [RL4]
        rst |=> !rd_valid && !tile_reset)
        else $error("outputs active in reset");

    // Main scenarios
    c_tile_reset: cover property (@(posedge clk) disable iff (rst) tile_reset);
    c_int_off: cover property (@(posedge clk) disable iff (rst) !ctrl.int_en);
    c_read: cover property (@(posedge clk) disable iff (rst) rd_valid && rd_data != 8'h00);
    c_xtal_off: cover property (@(posedge clk) disable iff (rst) !ctrl.xtal_en);
    c_slow: cover property (@(posedge clk) disable iff (rst) ctrl.int_slow);
endmodule : oscsc_top

// ---- oscsc_pkg.sv ----
package oscsc_pkg;
    // Peripheral identity and register offsets
    localparam logic [7:0] PERIPH_ID      = 8'h04;
    localparam logic [7:0] OFF_GENERAL    = 8'h00;
    localparam logic [7:0] OFF_INTERNAL   = 8'h01;
    localparam logic [7:0] OFF_CRYSTAL    = 8'h02;
    // Field positions
    localparam int         BIT_SRC_SEL    = 0;
    localparam int         BIT_RST_ON_CHG = 1;
    localparam int         BIT_INT_EN     = 0;
    localparam int         BIT_INT_SLOW   = 1;
    localparam int         BIT_XTAL_EN    = 0;
    localparam int         BIT_XTAL_BIAS  = 1;
    // Reset values of writable fields
    localparam logic       RST_RST_ON_CHG = 1'b0;
    localparam logic       RST_INT_SLOW   = 1'b0;
    localparam logic       RST_INT_EN     = 1'b1;
    localparam logic       RST_XTAL_BIAS  = 1'b1;
    localparam logic       RST_XTAL_EN    = 1'b1;
    localparam logic [7:0] ZERO_BYTE      = 8'h00;

    // Byte-wide peripheral access request
    typedef struct packed {
        logic       valid;
        logic       write;
        logic [7:0] periph;
        logic [7:0] addr;
        logic [7:0] wdata;
    } oscsc_req_t;

    // Oscillator control outputs
    typedef struct packed {
        logic src_internal;
        logic int_en;
        logic int_slow;
        logic xtal_en;
        logic xtal_bias_en;
    } oscsc_ctrl_t;
endpackage : oscsc_pkg

// ---- oscillator_select_control_tb.sv ----
`timescale 1ns/1ns
module oscillator_select_control_tb;
    logic                   clk = 1'b0;
    logic                   rst = 1'b1;
    logic                   strap_src_pin = 1'b1;
    oscsc_pkg::oscsc_req_t  req = '0;
    logic                   rd_valid;
    logic [7:0]             rd_data;
    oscsc_pkg::oscsc_ctrl_t ctrl;
    logic                   tile_reset;
    logic [7:0]             exp_q[$];
    logic [7:0]             m_reg[3];
    logic [7:0]             rnd;
    logic [7:0]             wd;
    logic [7:0]             exp_ctrl;
    int                     err_total = 0;
    int                     checks = 0;
    int                     cycles = 0;
    int                     pulses = 0;
    int                     exp_pulses = 0;

    oscsc_top DUT (.clk(clk), .rst(rst), .strap_src_pin(strap_src_pin), .req(req),
                   .rd_valid(rd_valid), .rd_data(rd_data), .ctrl(ctrl), .tile_reset(tile_reset));

    // Clock, 10 ns period
    always #5 clk = ~clk;

    task chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task print_verdict;
        $display("checks=%0d err_total=%0d", checks, err_total);
        if (err_total == 0 && checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : print_verdict

    // One byte access; model notes the expected read or updates
    task acc(input logic wr, input logic [7:0] per, input logic [7:0] a, input logic [7:0] d);
        req = '{1'b1, wr, per, a, d};
        if (per == oscsc_pkg::PERIPH_ID && !wr) begin
            exp_q.push_back(a < 8'h03 ? m_reg[a[1:0]] : 8'h00);
        end
        if (per == oscsc_pkg::PERIPH_ID && wr && a < 8'h03) begin
            if (a == 8'h00 && m_reg[0][1] && d[0] != m_reg[0][0]) exp_pulses++;
            m_reg[a[1:0]] = d & 8'h03;
        end
        @(posedge clk);
        #1;
    endtask : acc

    // Reset with a given strap level, then let the strap load land
    task do_reset(input logic s);
        rst = 1'b1;
        strap_src_pin = s;
        req.valid = 1'b0;
        repeat (4) @(posedge clk);
        #1;
        rst = 1'b0;
        m_reg = '{{7'h00, s}, 8'h01, 8'h03};
        @(posedge clk);
        #1;
    endtask : do_reset

    // Idle, then compare the control levels with the model
    task idle_ctrl;
        req.valid = 1'b0;
        repeat (2) @(posedge clk);
        #1;
        exp_ctrl = {3'h0, m_reg[0][0], m_reg[1][0], m_reg[1][1], m_reg[2][0], m_reg[2][1]};
        chk({3'h0, ctrl}, exp_ctrl);
    endtask : idle_ctrl

    // Read back all four offsets, the unmapped one included
    task read_all;
        for (int i = 0; i < 4; i++) begin
            acc(1'b0, oscsc_pkg::PERIPH_ID, 8'(i), 8'h00);
        end
    endtask : read_all

    // Read monitor takes the oldest note; tile reset pulses are counted
    always @(negedge clk) begin
        if (rd_valid === 1'b1) chk(rd_data, exp_q.size() > 0 ? exp_q.pop_front() : 8'hxx);
        if (tile_reset === 1'b1) pulses++;
    end

    // Hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            err_total++;
            print_verdict();
        end
    end

    // Main sequence
    initial begin
        void'($urandom(52));
        for (int k = 0; k < 2; k++) begin
            do_reset(k == 0);
            read_all();
            idle_ctrl();
        end
        acc(1'b1, 8'h03, 8'h00, 8'hff);
        acc(1'b0, 8'h03, 8'h01, 8'h00);
        acc(1'b0, 8'h04, 8'h00, 8'h00);
        acc(1'b1, 8'h04, 8'h00, 8'hfd);
        acc(1'b1, 8'h04, 8'h00, 8'h02);
        acc(1'b1, 8'h04, 8'h00, 8'h03);
        acc(1'b1, 8'h04, 8'h00, 8'h02);
        acc(1'b1, 8'h04, 8'h03, 8'hff);
        acc(1'b0, 8'h04, 8'h00, 8'h00);
        idle_ctrl();
        // Bench board has an external oscillator, so the bias may be cleared
        for (int i = 0; i < 40; i++) begin
            rnd = 8'($urandom);
            wd  = 8'($urandom);
            // Never stop the oscillator that clocks the tile
            if (rnd[1:0] == 2'h1 && m_reg[0][0]) wd[0] = 1'b1;
            if (rnd[1:0] == 2'h2 && !m_reg[0][0]) wd[0] = 1'b1;
            // Never select an oscillator that is stopped
            if (rnd[1:0] == 2'h0 && !m_reg[wd[0] ? 1 : 2][0]) begin
                wd[0] = m_reg[0][0];
            end
            acc(1'b1, 8'h04, {6'h00, rnd[1:0]}, wd);
            acc(1'b0, 8'h04, {6'h00, rnd[3:2]}, 8'h00);
        end
        idle_ctrl();
        // Reset after random writes must restore every field
        do_reset(1'b1);
        read_all();
        idle_ctrl();
        chk(8'(pulses), 8'(exp_pulses));
        print_verdict();
    end
endmodule : oscillator_select_control_tb
